/* File: i2c_regs.svh */
`ifndef I2C_REGS_SVH
`define I2C_REGS_SVH

`define MCLK_PERIOD_NS  10
`define STD_PERIOD_NS   10000
`define FAST_PERIOD_NS  2500
`define FASTP_PERIOD_NS 1000
`define HALF_CYC(p)     ((((p) / 2) + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define FLOOR_STD       10'(`HALF_CYC(`STD_PERIOD_NS))
`define FLOOR_FAST      10'(`HALF_CYC(`FAST_PERIOD_NS))
`define FLOOR_FASTP     10'(`HALF_CYC(`FASTP_PERIOD_NS))
`define FL_MAX          10'h3FF
`define PH_MAX          9'h1FF
`define BIT_ACK         4'h8
`define BIT_LAST        4'h7
`define HDR10_PFX       5'h1E
`define GCALL_ADDR      8'h00
`define CRC_POLY        8'h07
`define CRC_INIT        8'h00

`endif

/* File: i2c_pkg.sv */
`include "i2c_regs.svh"

package i2c_pkg;

	typedef enum logic [1:0] {
		SPD_STD   = 2'h0,
		SPD_FAST  = 2'h1,
		SPD_FASTP = 2'h2
	} speed_t;

	typedef enum logic [2:0] {
		OP_START = 3'h0,
		OP_WRITE = 3'h1,
		OP_READ  = 3'h2,
		OP_STOP  = 3'h3,
		OP_PEC   = 3'h4
	} cmd_op_t;

	typedef enum logic [1:0] {
		EVT_ADDR  = 2'h0,
		EVT_DATA  = 2'h1,
		EVT_TXREQ = 2'h2,
		EVT_STOP  = 2'h3
	} evt_kind_t;

	typedef enum logic [10:0] {
		M_IDLE  = 11'h001,
		M_WAIT  = 11'h002,
		M_SHOLD = 11'h004,
		M_LOW   = 11'h008,
		M_RISE  = 11'h010,
		M_HIGH  = 11'h020,
		M_RS1   = 11'h040,
		M_RS2   = 11'h080,
		M_P1    = 11'h100,
		M_P2    = 11'h200,
		M_P3    = 11'h400
	} m_state_t;

	typedef enum logic [5:0] {
		S_IDLE  = 6'h01,
		S_ADDR  = 6'h02,
		S_ADDR2 = 6'h04,
		S_RX    = 6'h08,
		S_TX    = 6'h10,
		S_IGN   = 6'h20
	} s_state_t;

	typedef struct packed {
		logic       master_en;
		logic       slave_en;
		logic       addr10;
		logic       gc_en;
		logic       rx_ack_en;
		logic       kernel_sel;
		logic [7:0] ker_div;
		speed_t     speed;
		logic [6:0] own1;
		logic [6:0] own2;
		logic [9:0] own10;
	} cfg_t;

	typedef struct packed {
		logic [3:0] psc;
		logic [7:0] clock_high_period;
		logic [7:0] clock_low_period;
		logic [3:0] setup;
		logic [3:0] hold;
	} timing_t;

	typedef struct packed {
		cmd_op_t    op;
		logic [9:0] addr;
		logic       addr10;
		logic       rw;
		logic [7:0] data;
		logic       ack;
	} cmd_t;

	typedef struct packed {
		logic       done;
		logic       ack;
		logic       arb_lost;
		logic       bad;
		logic [7:0] data;
	} mst_rsp_t;

	typedef struct packed {
		logic       valid;
		evt_kind_t  kind;
		logic [7:0] data;
		logic       gcall;
		logic       pec_ok;
	} slv_evt_t;

	typedef struct packed {
		logic scl;
		logic sda;
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
	} line_t;

	function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] d);
		logic [7:0] c;
		c = crc ^ d;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ((c << 1) ^ `CRC_POLY) : (c << 1);
		end
		return c;
	endfunction : crc8

	function automatic logic [7:0] addr_byte(input cmd_t c);
		return c.addr10 ? {`HDR10_PFX, c.addr[9:8], c.rw} : {c.addr[6:0], c.rw};
	endfunction : addr_byte

endpackage : i2c_pkg

/* File: i2c_line_sync.sv */
`timescale 1ns/10ps
`default_nettype none

module i2c_line_sync (
	input  wire logic            mclk,
	input  wire logic            rst_n,
	input  wire logic            scl_i,
	input  wire logic            sda_i,
	output var  i2c_pkg::line_t  line
);

	logic scl_m_r;
	logic scl_s_r;
	logic scl_q_r;
	logic sda_m_r;
	logic sda_s_r;
	logic sda_q_r;

	// Idle lines read high, so reset to high avoids a false clock rise
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			scl_m_r <= 1'b1;
			scl_s_r <= 1'b1;
			scl_q_r <= 1'b1;
			sda_m_r <= 1'b1;
			sda_s_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			scl_m_r <= scl_i;
			scl_s_r <= scl_m_r;
			scl_q_r <= scl_s_r;
			sda_m_r <= sda_i;
			sda_s_r <= sda_m_r;
			sda_q_r <= sda_s_r;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			line <= '{scl: 1'b1, sda: 1'b1, default: 1'b0};
		end else begin
			line.scl      <= scl_s_r;
			line.sda      <= sda_s_r;
			line.scl_rise <= scl_s_r & ~scl_q_r;
			line.scl_fall <= ~scl_s_r & scl_q_r;
			line.start    <= scl_s_r & scl_q_r & sda_q_r & ~sda_s_r;
			line.stop     <= scl_s_r & scl_q_r & ~sda_q_r & sda_s_r;
		end
	end

endmodule : i2c_line_sync

`default_nettype wire

/* File: i2c_bus_interface.sv */
`timescale 1ns/10ps
`default_nettype none
`include "i2c_regs.svh"

// What this block does
// - Two lines, each driven and sensed.
// - Bits move on data, timed by clock.
// - Master or slave role, shared bus.
// - Seven or ten bit addressing selectable.
// - Two own seven bit addresses or one ten bit address, plus broadcast.
// - Lines only pulled low, else released.
// - Three speed grades cap clock rate.
// - Arbitration leaves exactly one master.
// - Clock high, low, setup, hold programmable.
// - Packet error check, software acknowledge control.
// - Bus timing from selectable kernel clock.
// - Start/stop only with clock high.
// - Ninth clock carries receiver acknowledge.
module i2c_bus_interface (
	input  wire logic              mclk,
	input  wire logic              rstn,
	input  wire i2c_pkg::cfg_t     cfg,
	input  wire i2c_pkg::timing_t  timing,
	input  wire logic              cmd_valid,
	input  wire i2c_pkg::cmd_t     cmd,
	output var  logic              cmd_ready,
	output var  i2c_pkg::mst_rsp_t mst_rsp,
	input  wire logic [7:0]        slv_tx_data,
	output var  i2c_pkg::slv_evt_t slv_evt,
	output var  logic              bus_busy,
	output var  logic [7:0]        pec_value,
	input  wire logic              scl_i,
	output var  logic              scl_o,
	output var  logic              scl_oe_n,
	input  wire logic              sda_i,
	output var  logic              sda_o,
	output var  logic              sda_oe_n
);

	logic                rst_m_r;
	logic                rst_n_r;
	i2c_pkg::line_t      line;
	logic [7:0]          ker_cnt_r;
	logic [3:0]          psc_cnt_r;
	logic                ker_tick;
	logic                tick;
	logic [9:0]          floor_min;
	logic [8:0]          ph_cnt_r;
	logic [9:0]          fl_cnt_r;
	logic                ph_new;
	logic                t_hold;
	logic                t_low;
	logic                t_high;
	i2c_pkg::m_state_t   m_st_r;
	i2c_pkg::m_state_t   m_st_q_r;
	logic [3:0]          m_bit_r;
	logic [7:0]          m_sh_r;
	logic                m_tx_r;
	logic                m_ack_send_r;
	logic                m_lo2_r;
	logic [7:0]          m_lo2_byte_r;
	logic                m_ackrx_r;
	logic                m_scl_low_r;
	logic                m_sda_low_r;
	logic                m_drive;
	logic                m_want_low;
	logic                accept;
	i2c_pkg::s_state_t   s_st_r;
	logic                s_sda_low_r;
	logic [7:0]          s_tx_sh_r;
	logic                a10_hit_r;
	logic                hit7;
	logic                hit10h;
	logic [3:0]          obs_cnt_r;
	logic [7:0]          obs_sh_r;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rst_m_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_m_r <= 1'b1;
			rst_n_r <= rst_m_r;
		end
	end

	i2c_line_sync u_sync (
		.mclk  (mclk),
		.rst_n (rst_n_r),
		.scl_i (scl_i),
		.sda_i (sda_i),
		.line  (line)
	);

	// Kernel rate either mclk itself or a divided enable
	assign ker_tick = !cfg.kernel_sel || (ker_cnt_r == cfg.ker_div);
	assign tick     = ker_tick && (psc_cnt_r == timing.psc);

	always_ff @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ker_cnt_r <= 8'h00;
			psc_cnt_r <= 4'h0;
		end else begin
			ker_cnt_r <= (ker_tick || !cfg.kernel_sel) ? 8'h00 : ker_cnt_r + 8'h01;
			if (tick)
				psc_cnt_r <= 4'h0;
			else if (ker_tick)
				psc_cnt_r <= psc_cnt_r + 4'h1;
		end
	end

	// Floor in mclk cycles keeps each half period legal whatever is programmed
	always_comb begin
		unique case (cfg.speed)
			i2c_pkg::SPD_STD:   floor_min = `FLOOR_STD;
			i2c_pkg::SPD_FAST:  floor_min = `FLOOR_FAST;
			i2c_pkg::SPD_FASTP: floor_min = `FLOOR_FASTP;
			default:            floor_min = `FLOOR_STD;
		endcase
	end

	assign ph_new = (m_st_q_r != m_st_r);

	always_ff @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			m_st_q_r <= i2c_pkg::M_IDLE;
			ph_cnt_r <= 9'h000;
			fl_cnt_r <= 10'h000;
		end else begin
			m_st_q_r <= m_st_r;
			if (ph_new) begin
				ph_cnt_r <= 9'h000;
				fl_cnt_r <= 10'h000;
			end else begin
				if (tick && ph_cnt_r != `PH_MAX)
					ph_cnt_r <= ph_cnt_r + 9'h001;
				if (fl_cnt_r != `FL_MAX)
					fl_cnt_r <= fl_cnt_r + 10'h001;
			end
		end
	end

	assign t_hold = !ph_new && ph_cnt_r >= {5'h00, timing.hold};
	assign t_low  = t_hold && fl_cnt_r >= floor_min
		&& ph_cnt_r >= {1'b0, timing.clock_low_period}
		&& ph_cnt_r >= {4'h0, {1'b0, timing.hold} + {1'b0, timing.setup}};
	assign t_high = !ph_new && fl_cnt_r >= floor_min
		&& ph_cnt_r >= {1'b0, timing.clock_high_period};

	assign m_drive    = m_tx_r ? (m_bit_r != `BIT_ACK) : (m_bit_r == `BIT_ACK);
	assign m_want_low = m_drive && ((m_bit_r == `BIT_ACK) ? m_ack_send_r : !m_sh_r[7]);
	assign accept     = cmd_valid && cmd_ready;

	always_ff @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r)
			cmd_ready <= 1'b0;
		else
			cmd_ready <= cfg.master_en && !accept && ((m_st_r == i2c_pkg::M_WAIT)
				|| (m_st_r == i2c_pkg::M_IDLE && !bus_busy && line.scl && line.sda));
	end

	always_ff @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			m_st_r       <= i2c_pkg::M_IDLE;
			m_bit_r      <= 4'h0;
			m_sh_r       <= 8'h00;
			m_tx_r       <= 1'b1;
			m_ack_send_r <= 1'b0;
			m_lo2_r      <= 1'b0;
			m_lo2_byte_r <= 8'h00;
			m_ackrx_r    <= 1'b0;
			m_scl_low_r  <= 1'b0;
			m_sda_low_r  <= 1'b0;
			mst_rsp      <= '0;
		end else begin
			mst_rsp.done     <= 1'b0;
			mst_rsp.arb_lost <= 1'b0;
			mst_rsp.bad      <= 1'b0;
			unique case (m_st_r)
				i2c_pkg::M_IDLE: begin
					if (accept && cmd.op == i2c_pkg::OP_START && !bus_busy) begin
						m_sh_r       <= i2c_pkg::addr_byte(cmd);
						m_lo2_r      <= cmd.addr10 && !cmd.rw;
						m_lo2_byte_r <= cmd.addr[7:0];
						m_tx_r       <= 1'b1;
						m_sda_low_r  <= 1'b1;
						m_st_r       <= i2c_pkg::M_SHOLD;
					end else if (accept) begin
						mst_rsp.done <= 1'b1;
						mst_rsp.bad  <= 1'b1;
					end
				end
				i2c_pkg::M_WAIT: begin
					if (t_hold)
						m_sda_low_r <= 1'b0;
					if (accept) begin
						m_bit_r <= 4'h0;
						m_tx_r  <= 1'b1;
						unique case (cmd.op)
							i2c_pkg::OP_START: begin
								m_sh_r       <= i2c_pkg::addr_byte(cmd);
								m_lo2_r      <= cmd.addr10 && !cmd.rw;
								m_lo2_byte_r <= cmd.addr[7:0];
								m_st_r       <= i2c_pkg::M_RS1;
							end
							i2c_pkg::OP_WRITE: begin
								m_sh_r <= cmd.data;
								m_st_r <= i2c_pkg::M_LOW;
							end
							i2c_pkg::OP_PEC: begin
								m_sh_r <= pec_value;
								m_st_r <= i2c_pkg::M_LOW;
							end
							i2c_pkg::OP_READ: begin
								m_tx_r       <= 1'b0;
								m_ack_send_r <= cmd.ack;
								m_st_r       <= i2c_pkg::M_LOW;
							end
							i2c_pkg::OP_STOP: m_st_r <= i2c_pkg::M_P1;
							default: begin
								mst_rsp.done <= 1'b1;
								mst_rsp.bad  <= 1'b1;
							end
						endcase
					end
				end
				i2c_pkg::M_SHOLD: begin
					if (t_high) begin
						m_scl_low_r <= 1'b1;
						m_bit_r     <= 4'h0;
						m_st_r      <= i2c_pkg::M_LOW;
					end
				end
				i2c_pkg::M_LOW: begin
					if (t_hold)
						m_sda_low_r <= m_want_low;
					if (t_low) begin
						m_scl_low_r <= 1'b0;
						m_st_r      <= i2c_pkg::M_RISE;
					end
				end
				i2c_pkg::M_RISE: begin
					// Waiting for the sensed high lets a slower master stretch us
					if (line.scl) begin
						m_ackrx_r <= !line.sda;
						if (m_drive && !m_sda_low_r && !line.sda) begin
							m_sda_low_r      <= 1'b0;
							mst_rsp.done     <= 1'b1;
							mst_rsp.arb_lost <= 1'b1;
							m_st_r           <= i2c_pkg::M_IDLE;
						end else begin
							m_st_r <= i2c_pkg::M_HIGH;
						end
					end
				end
				i2c_pkg::M_HIGH: begin
					if (t_high) begin
						m_scl_low_r <= 1'b1;
						m_sh_r      <= {m_sh_r[6:0], 1'b0};
						if (m_bit_r != `BIT_ACK) begin
							m_bit_r <= m_bit_r + 4'h1;
							m_st_r  <= i2c_pkg::M_LOW;
						end else if (m_lo2_r && m_ackrx_r) begin
							m_lo2_r <= 1'b0;
							m_sh_r  <= m_lo2_byte_r;
							m_bit_r <= 4'h0;
							m_st_r  <= i2c_pkg::M_LOW;
						end else begin
							m_lo2_r      <= 1'b0;
							m_bit_r      <= 4'h0;
							mst_rsp.done <= 1'b1;
							mst_rsp.ack  <= m_ackrx_r;
							mst_rsp.data <= obs_sh_r;
							m_st_r       <= i2c_pkg::M_WAIT;
						end
					end
				end
				i2c_pkg::M_RS1: begin
					if (t_hold)
						m_sda_low_r <= 1'b0;
					if (t_low) begin
						m_scl_low_r <= 1'b0;
						m_st_r      <= i2c_pkg::M_RS2;
					end
				end
				i2c_pkg::M_RS2: begin
					if (line.scl && !line.sda) begin
						mst_rsp.done     <= 1'b1;
						mst_rsp.arb_lost <= 1'b1;
						m_st_r           <= i2c_pkg::M_IDLE;
					end else if (line.scl && t_high) begin
						m_sda_low_r <= 1'b1;
						m_st_r      <= i2c_pkg::M_SHOLD;
					end
				end
				i2c_pkg::M_P1: begin
					if (t_hold)
						m_sda_low_r <= 1'b1;
					if (t_low) begin
						m_scl_low_r <= 1'b0;
						m_st_r      <= i2c_pkg::M_P2;
					end
				end
				i2c_pkg::M_P2: begin
					if (line.scl && t_high) begin
						m_sda_low_r <= 1'b0;
						m_st_r      <= i2c_pkg::M_P3;
					end
				end
				i2c_pkg::M_P3: begin
					if (t_low) begin
						mst_rsp.done <= 1'b1;
						m_st_r       <= i2c_pkg::M_IDLE;
					end
				end
			endcase
		end
	end

	// Byte observer sees every byte on the wire, ours or not
	always_ff @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			obs_cnt_r <= 4'h0;
			obs_sh_r  <= 8'h00;
			pec_value <= `CRC_INIT;
			bus_busy  <= 1'b0;
		end else if (line.start) begin
			obs_cnt_r <= 4'h0;
			bus_busy  <= 1'b1;
			if (!bus_busy)
				pec_value <= `CRC_INIT;
		end else if (line.stop) begin
			bus_busy <= 1'b0;
		end else if (line.scl_rise) begin
			if (obs_cnt_r == `BIT_ACK) begin
				obs_cnt_r <= 4'h0;
			end else begin
				obs_sh_r  <= {obs_sh_r[6:0], line.sda};
				obs_cnt_r <= obs_cnt_r + 4'h1;
				if (obs_cnt_r == `BIT_LAST)
					pec_value <= i2c_pkg::crc8(pec_value, {obs_sh_r[6:0], line.sda});
			end
		end
	end

	assign hit7 = (!cfg.addr10 && (obs_sh_r[7:1] == cfg.own1 || obs_sh_r[7:1] == cfg.own2))
		|| (cfg.gc_en && obs_sh_r == `GCALL_ADDR);
	assign hit10h = cfg.addr10 && obs_sh_r[7:3] == `HDR10_PFX
		&& obs_sh_r[2:1] == cfg.own10[9:8];

	always_ff @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			s_st_r      <= i2c_pkg::S_IDLE;
			s_sda_low_r <= 1'b0;
			s_tx_sh_r   <= 8'h00;
			a10_hit_r   <= 1'b0;
			slv_evt     <= '0;
		end else begin
			slv_evt.valid  <= 1'b0;
			slv_evt.data   <= obs_sh_r;
			slv_evt.pec_ok <= (pec_value == `CRC_INIT);
			if (!cfg.slave_en || m_st_r != i2c_pkg::M_IDLE) begin
				s_st_r      <= i2c_pkg::S_IDLE;
				s_sda_low_r <= 1'b0;
			end else if (line.stop) begin
				slv_evt.valid <= (s_st_r != i2c_pkg::S_IDLE && s_st_r != i2c_pkg::S_IGN);
				slv_evt.kind  <= i2c_pkg::EVT_STOP;
				s_st_r        <= i2c_pkg::S_IDLE;
				s_sda_low_r   <= 1'b0;
				a10_hit_r     <= 1'b0;
			end else if (line.start) begin
				s_st_r      <= i2c_pkg::S_ADDR;
				s_sda_low_r <= 1'b0;
			end else if (line.scl_fall) begin
				s_sda_low_r <= 1'b0;
				if (obs_cnt_r == `BIT_ACK) begin
					unique case (s_st_r)
						i2c_pkg::S_ADDR: begin
							if (hit7) begin
								s_sda_low_r   <= 1'b1;
								slv_evt.valid <= 1'b1;
								slv_evt.kind  <= i2c_pkg::EVT_ADDR;
								slv_evt.gcall <= (obs_sh_r == `GCALL_ADDR);
								s_st_r <= obs_sh_r[0] ? i2c_pkg::S_TX : i2c_pkg::S_RX;
							end else if (hit10h && (!obs_sh_r[0] || a10_hit_r)) begin
								s_sda_low_r   <= 1'b1;
								slv_evt.valid <= obs_sh_r[0];
								slv_evt.kind  <= i2c_pkg::EVT_ADDR;
								slv_evt.gcall <= 1'b0;
								s_st_r <= obs_sh_r[0] ? i2c_pkg::S_TX : i2c_pkg::S_ADDR2;
							end else begin
								s_st_r <= i2c_pkg::S_IGN;
							end
						end
						i2c_pkg::S_ADDR2: begin
							if (obs_sh_r == cfg.own10[7:0]) begin
								s_sda_low_r   <= 1'b1;
								a10_hit_r     <= 1'b1;
								slv_evt.valid <= 1'b1;
								slv_evt.kind  <= i2c_pkg::EVT_ADDR;
								slv_evt.gcall <= 1'b0;
								s_st_r        <= i2c_pkg::S_RX;
							end else begin
								s_st_r <= i2c_pkg::S_IGN;
							end
						end
						i2c_pkg::S_RX: begin
							s_sda_low_r   <= cfg.rx_ack_en;
							slv_evt.valid <= 1'b1;
							slv_evt.kind  <= i2c_pkg::EVT_DATA;
						end
						i2c_pkg::S_IDLE, i2c_pkg::S_TX, i2c_pkg::S_IGN: ;
					endcase
				end else if (s_st_r == i2c_pkg::S_TX) begin
					s_sda_low_r <= !s_tx_sh_r[3'(`BIT_LAST - obs_cnt_r)];
				end
			end else if (line.scl_rise && obs_cnt_r == `BIT_ACK && s_st_r == i2c_pkg::S_TX) begin
				if (line.sda) begin
					s_st_r <= i2c_pkg::S_IGN;
				end else begin
					s_tx_sh_r     <= slv_tx_data;
					slv_evt.valid <= 1'b1;
					slv_evt.kind  <= i2c_pkg::EVT_TXREQ;
				end
			end
		end
	end

	// Open drain: the driven level is always low, only the enables move
	always_ff @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			scl_o    <= 1'b0;
			sda_o    <= 1'b0;
			scl_oe_n <= 1'b1;
			sda_oe_n <= 1'b1;
		end else begin
			scl_o    <= 1'b0;
			sda_o    <= 1'b0;
			scl_oe_n <= !m_scl_low_r;
			sda_oe_n <= !(m_sda_low_r || s_sda_low_r);
		end
	end

endmodule : i2c_bus_interface

`default_nettype wire

/* File: i2c_bus_interface_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
`include "i2c_regs.svh"

module i2c_bus_interface_monitor (
	input wire logic              mclk,
	input wire logic              rstn,
	input wire i2c_pkg::cfg_t     cfg,
	input wire i2c_pkg::timing_t  timing,
	input wire logic              cmd_valid,
	input wire i2c_pkg::cmd_t     cmd,
	input wire logic              cmd_ready,
	input wire i2c_pkg::mst_rsp_t mst_rsp,
	input wire logic [7:0]        slv_tx_data,
	input wire i2c_pkg::slv_evt_t slv_evt,
	input wire logic              bus_busy,
	input wire logic [7:0]        pec_value,
	input wire logic              scl_i,
	input wire logic              scl_o,
	input wire logic              scl_oe_n,
	input wire logic              sda_i,
	input wire logic              sda_o,
	input wire logic              sda_oe_n
);
	logic [9:0] low_cnt_r;
	logic [9:0] floor_min;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	// Saturates so a stuck line cannot wrap into a failure
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			low_cnt_r <= '0;
		else if (scl_oe_n)
			low_cnt_r <= '0;
		else if (low_cnt_r != `FL_MAX)
			low_cnt_r <= low_cnt_r + 10'h1;
	end

	always_comb begin
		case (cfg.speed)
			i2c_pkg::SPD_FAST:  floor_min = `FLOOR_FAST;
			i2c_pkg::SPD_FASTP: floor_min = `FLOOR_FASTP;
			default:            floor_min = `FLOOR_STD;
		endcase
	end

	sequence s_take;
		cmd_valid && cmd_ready;
	endsequence
	sequence s_idle_misuse;
		s_take ##0 (!bus_busy && cmd.op != i2c_pkg::OP_START);
	endsequence

	AST_PULL_ONLY: assert property (scl_o == 1'h0 && sda_o == 1'h0)
		else $error("line driven high");
	AST_RESET_IDLE: assert property (disable iff (1'h0) !rstn |=> scl_oe_n && sda_oe_n && !bus_busy && !cmd_ready)
		else $error("lines not released in reset");
	AST_READY_DROP: assert property (s_take |=> !cmd_ready)
		else $error("ready stays high after take");
	AST_DONE_PULSE: assert property (mst_rsp.done |=> !mst_rsp.done)
		else $error("done longer than one cycle");
	AST_IDLE_BAD: assert property (s_idle_misuse |-> ##[1:2] (mst_rsp.done && mst_rsp.bad))
		else $error("data op on idle bus not refused");
	AST_ARB_DONE: assert property (mst_rsp.arb_lost |-> mst_rsp.done)
		else $error("arbitration loss without done");
	AST_ARB_RELEASE: assert property (mst_rsp.arb_lost |-> scl_oe_n && sda_oe_n)
		else $error("lines held after arbitration loss");
	AST_START_HIGH: assert property ($fell(sda_oe_n) && scl_i |-> ##[1:10] bus_busy)
		else $error("data pulled while clock high outside start");
	AST_STOP_HIGH: assert property ($rose(sda_oe_n) && scl_i |-> ##[1:10] !bus_busy)
		else $error("data released while clock high outside stop");
	AST_LOW_MIN: assert property ($rose(scl_oe_n) |-> low_cnt_r >= floor_min - 10'h1)
		else $error("clock low phase below speed floor");
	AST_ACK_SLOT: assert property (slv_evt.valid && (slv_evt.kind == i2c_pkg::EVT_ADDR
		|| (slv_evt.kind == i2c_pkg::EVT_DATA && cfg.rx_ack_en)) |-> ##[0:1] !sda_oe_n)
		else $error("no acknowledge in ninth clock");
endmodule : i2c_bus_interface_monitor

bind i2c_bus_interface i2c_bus_interface_monitor i2c_bus_interface_monitor_i (
	.mclk(mclk), .rstn(rstn), .cfg(cfg), .timing(timing), .cmd_valid(cmd_valid), .cmd(cmd),
	.cmd_ready(cmd_ready), .mst_rsp(mst_rsp), .slv_tx_data(slv_tx_data), .slv_evt(slv_evt),
	.bus_busy(bus_busy), .pec_value(pec_value), .scl_i(scl_i), .scl_o(scl_o),
	.scl_oe_n(scl_oe_n), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n)
);

`default_nettype wire

/* File: i2c_bus_partner.sv */
`timescale 1ns/10ps
`default_nettype none
`include "i2c_regs.svh"

module i2c_bus_partner #(
	parameter logic [6:0] A7    = 7'h50,
	parameter logic [9:0] A10   = 10'h250,
	parameter logic [7:0] RDATA = 8'hA5
) (
	input  wire logic scl,
	input  wire logic sda,
	output var  logic scl_rel,
	output var  logic sda_rel
);
	logic [7:0] last_rx = 8'h00;
	logic       jam     = 1'h0;

	// Open drain: only ever releases or pulls low
	initial begin
		scl_rel = 1'h1;
		sda_rel = 1'h1;
	end

	task automatic rx(output logic [7:0] b);
		repeat (8) @(posedge scl) b = {b[6:0], sda};
	endtask : rx

	// Leaves the line low; caller decides when to let go
	task automatic ack();
		@(negedge scl) #100 sda_rel <= 1'h0;
		@(negedge scl);
	endtask : ack

	task automatic wr();
		logic [7:0] b;
		forever begin
			#100 sda_rel <= !jam;
			if (jam) begin
				@(posedge scl) #100 sda_rel <= 1'h1;
				jam = 1'h0;
				return;
			end
			rx(b);
			last_rx = b;
			ack();
		end
	endtask : wr

	task automatic rd();
		forever begin
			for (int i = 7; i >= 0; i--) begin
				#100 sda_rel <= RDATA[i];
				@(negedge scl);
			end
			#100 sda_rel <= 1'h1;
			@(posedge scl);
			if (sda)
				return;
			@(negedge scl);
		end
	endtask : rd

	task automatic frame();
		logic [7:0] b;
		rx(b);
		if (b == {`HDR10_PFX, A10[9:8], 1'h0}) begin
			ack();
			#100 sda_rel <= 1'h1;
			rx(b);
			if (b != A10[7:0])
				return;
			ack();
			wr();
		end else if (b[7:1] == A7) begin
			ack();
			if (b[0])
				rd();
			else
				wr();
		end
	endtask : frame

	always begin : slave_role
		@(negedge sda iff scl === 1'h1);
		fork
			frame();
			@(posedge sda iff scl === 1'h1);
		join_any
		disable fork;
	end

	// Clock of 125 ns, still outside frames
	task automatic mbit(input logic b, output logic s);
		#31 sda_rel <= b;
		#31 scl_rel <= 1'h1;
		#31 s = sda;
		#32 scl_rel <= 1'h0;
	endtask : mbit

	task automatic mstart();
		sda_rel <= 1'h0;
		#62 scl_rel <= 1'h0;
	endtask : mstart

	task automatic mstop();
		#31 sda_rel <= 1'h0;
		#31 scl_rel <= 1'h1;
		#62 sda_rel <= 1'h1;
		#62;
	endtask : mstop

	task automatic mbyte(input logic [7:0] d, output logic ak);
		logic s;
		for (int i = 7; i >= 0; i--)
			mbit(d[i], s);
		mbit(1'h1, s);
		ak = !s;
	endtask : mbyte
endmodule : i2c_bus_partner

`default_nettype wire

/* File: i2c_bus_interface_test.sv */
`timescale 1ns/10ps
`default_nettype none
`include "i2c_regs.svh"

module i2c_bus_interface_test;
	logic              mclk;
	logic              rstn;
	i2c_pkg::cfg_t     cfg;
	i2c_pkg::timing_t  timing;
	logic              cmd_valid;
	i2c_pkg::cmd_t     cmd;
	logic              cmd_ready;
	i2c_pkg::mst_rsp_t mst_rsp;
	i2c_pkg::mst_rsp_t rsp;
	i2c_pkg::slv_evt_t slv_evt;
	i2c_pkg::slv_evt_t evq[$];
	logic              bus_busy;
	logic [7:0]        pec_value;
	logic              scl_o;
	logic              scl_oe_n;
	logic              sda_o;
	logic              sda_oe_n;
	logic              p_scl_rel;
	logic              p_sda_rel;
	wire               scl_line;
	wire               sda_line;
	int                n_mismatch = 0;
	int                n_tests = 0;
	int                cyc = 0;

	// Wired-AND with pull-ups
	assign scl_line = (scl_oe_n | scl_o) & p_scl_rel;
	assign sda_line = (sda_oe_n | sda_o) & p_sda_rel;

	i2c_bus_interface i2c_bus_interface_i (
		.mclk(mclk), .rstn(rstn), .cfg(cfg), .timing(timing), .cmd_valid(cmd_valid), .cmd(cmd),
		.cmd_ready(cmd_ready), .mst_rsp(mst_rsp), .slv_tx_data(8'hC3), .slv_evt(slv_evt),
		.bus_busy(bus_busy), .pec_value(pec_value), .scl_i(scl_line), .scl_o(scl_o),
		.scl_oe_n(scl_oe_n), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n)
	);
	i2c_bus_partner i2c_bus_partner_i (
		.scl(scl_line), .sda(sda_line), .scl_rel(p_scl_rel), .sda_rel(p_sda_rel)
	);

	initial begin
		mclk = 1'h0;
		forever #5 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cyc++;
		if (slv_evt.valid === 1'h1)
			evq.push_back(slv_evt);
		if (cyc == 60000) begin
			n_mismatch++;
			print_verdict();
		end
	end

	function automatic logic [7:0] crc_upd(input logic [7:0] c, input logic [7:0] d);
		c ^= d;
		repeat (8) c = c[7] ? ({c[6:0], 1'h0} ^ `CRC_POLY) : {c[6:0], 1'h0};
		return c;
	endfunction : crc_upd

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict

	task automatic do_cmd(input i2c_pkg::cmd_op_t op, input logic [9:0] a, input logic a10,
		input logic rw, input logic [7:0] d, input logic ak);
		do @(negedge mclk); while (cmd_ready !== 1'h1);
		@(posedge mclk);
		cmd_valid <= 1'h1;
		cmd       <= '{op, a, a10, rw, d, ak};
		// Hold the request up to the edge that takes it, or it is taken twice
		do @(posedge mclk); while (cmd_ready !== 1'h1);
		cmd_valid <= 1'h0;
		do @(negedge mclk); while (mst_rsp.done !== 1'h1);
		rsp = mst_rsp;
	endtask : do_cmd

	task automatic t_write();
		do_cmd(i2c_pkg::OP_START, 10'h050, 1'h0, 1'h0, 8'h00, 1'h0);
		chk("addr_ack", 8'h01, {7'h0, rsp.ack});
		chk("busy", 8'h01, {7'h0, bus_busy});
		do_cmd(i2c_pkg::OP_WRITE, 10'h050, 1'h0, 1'h0, 8'h3C, 1'h0);
		chk("wr_ack", 8'h01, {7'h0, rsp.ack});
		chk("wr_data", 8'h3C, i2c_bus_partner_i.last_rx);
		chk("pec", crc_upd(crc_upd(8'h00, 8'hA0), 8'h3C), pec_value);
		do_cmd(i2c_pkg::OP_STOP, 10'h050, 1'h0, 1'h0, 8'h00, 1'h0);
		chk("free", 8'h00, {7'h0, bus_busy});
	endtask : t_write

	task automatic t_read_nack();
		do_cmd(i2c_pkg::OP_START, 10'h050, 1'h0, 1'h1, 8'h00, 1'h0);
		chk("rd_addr_ack", 8'h01, {7'h0, rsp.ack});
		do_cmd(i2c_pkg::OP_READ, 10'h050, 1'h0, 1'h1, 8'h00, 1'h0);
		chk("rd_data", 8'hA5, rsp.data);
		do_cmd(i2c_pkg::OP_STOP, 10'h050, 1'h0, 1'h0, 8'h00, 1'h0);
		do_cmd(i2c_pkg::OP_START, 10'h051, 1'h0, 1'h0, 8'h00, 1'h0);
		chk("absent_nack", 8'h00, {7'h0, rsp.ack});
		do_cmd(i2c_pkg::OP_STOP, 10'h051, 1'h0, 1'h0, 8'h00, 1'h0);
	endtask : t_read_nack

	task automatic t_wide_arb();
		do_cmd(i2c_pkg::OP_START, 10'h250, 1'h1, 1'h0, 8'h00, 1'h0);
		chk("a10_ack", 8'h01, {7'h0, rsp.ack});
		do_cmd(i2c_pkg::OP_WRITE, 10'h250, 1'h1, 1'h0, 8'h77, 1'h0);
		chk("a10_data", 8'h77, i2c_bus_partner_i.last_rx);
		i2c_bus_partner_i.jam = 1'h1;
		do_cmd(i2c_pkg::OP_WRITE, 10'h250, 1'h1, 1'h0, 8'hFF, 1'h0);
		chk("arb_lost", 8'h01, {7'h0, rsp.arb_lost});
		for (int n = 0; n < 100 && bus_busy !== 1'h0; n++)
			@(negedge mclk);
		chk("arb_free", 8'h00, {7'h0, bus_busy});
	endtask : t_wide_arb

	task automatic t_slave();
		logic [6:0] al[4] = '{7'h3A, 7'h45, 7'h00, 7'h11};
		logic       ak;
		for (int k = 0; k < 4; k++) begin
			evq.delete();
			i2c_bus_partner_i.mstart();
			i2c_bus_partner_i.mbyte({al[k], 1'h0}, ak);
			chk("own_ack", {7'h0, k < 3}, {7'h0, ak});
			if (k < 3) begin
				i2c_bus_partner_i.mbyte(8'h5A, ak);
				chk("rx_ack", 8'h01, {7'h0, ak});
			end
			i2c_bus_partner_i.mstop();
			repeat (10) @(negedge mclk);
			if (k < 3) begin
				chk("evt_n", 8'h03, 8'(evq.size()));
				chk("evt_addr", 8'(i2c_pkg::EVT_ADDR), {6'h0, evq[0].kind});
				chk("gcall", {7'h0, k == 2}, {7'h0, evq[0].gcall});
				chk("evt_data", 8'h5A, evq[1].data);
			end
		end
	endtask : t_slave

	initial begin
		rstn      = 1'h0;
		cmd_valid = 1'h0;
		cmd       = '0;
		cfg       = '{1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 8'h00, i2c_pkg::SPD_FASTP,
			7'h3A, 7'h45, 10'h000};
		timing    = '{4'h0, 8'h02, 8'h02, 4'h1, 4'h1};
		repeat (6) @(posedge mclk);
		chk("rst_ready", 8'h00, {7'h0, cmd_ready});
		chk("rst_oe", 8'h03, {6'h0, scl_oe_n, sda_oe_n});
		chk("rst_pec", 8'h00, pec_value | {7'h0, bus_busy});
		rstn <= 1'h1;
		do_cmd(i2c_pkg::OP_WRITE, 10'h050, 1'h0, 1'h0, 8'h11, 1'h0);
		chk("idle_bad", 8'h01, {7'h0, rsp.bad});
		t_write();
		t_read_nack();
		t_wide_arb();
		t_slave();
		print_verdict();
	end
endmodule : i2c_bus_interface_test

`default_nettype wire
